// ### test/mdc_osc_model.sv
// Behavioural model of the oscillator taps, counter A terminal and external clock.
`timescale 1ns/1ps
module mdc_osc_model #(
  parameter int FAST_P = 2,
  parameter int SLOW_P = 3,
  parameter int TERM_P = 5,
  parameter int EXT_P  = 6
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  output logic      fast_osc_en,
  output logic      slow_osc_en,
  output logic      counter_a_terminal,
  output logic      external_count_clock
);
  int cnt_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= (cnt_r == 29) ? 0 : cnt_r + 1;
    end
  end

  assign fast_osc_en          = (cnt_r % FAST_P) == 0;
  assign slow_osc_en          = (cnt_r % SLOW_P) == 0;
  assign counter_a_terminal   = (cnt_r % TERM_P) == 0;
  assign external_count_clock = (cnt_r % EXT_P) < (EXT_P / 2);
endmodule // mdc_osc_model

// ### test/tb_top.sv
// Self-checking testbench for the multifunction delay counter block.
`timescale 1ns/1ps
module tb_top;
  import mdc_pkg::*;
  localparam logic [11:0] A_BF = {IDX_B_FUNC, 2'b00};
  localparam logic [11:0] A_BC = {IDX_B_CLK, 2'b00};
  localparam logic [11:0] A_CW = {IDX_C_FUNC, 2'b00};
  localparam logic [11:0] A_ST = {IDX_STATUS, 2'b00};
  logic         clk_sys = 1'b0;
  logic         nrst    = 1'b0;
  mdc_apb_req_t req     = '0;
  mdc_apb_rsp_t rsp;
  logic         fe, se, ta, ec;
  logic         din     = 1'b0;
  mdc_matrix_t  mx      = '0;
  logic         bout, mout;
  int           err_total = 0;
  int           samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  mdc_osc_model u_mdc_osc_model (.clk_sys(clk_sys), .nrst(nrst), .fast_osc_en(fe),
    .slow_osc_en(se), .counter_a_terminal(ta), .external_count_clock(ec));
  mdc_top u_mdc_top (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .fast_osc_en(fe), .slow_osc_en(se), .counter_a_terminal(ta),
    .external_count_clock(ec), .delay_input(din), .mcc_matrix(mx),
    .counter_b_out(bout), .mcc_out(mout));

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        err_total++;
        stop_test();
      end
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic wait_b(input logic v, input int bound, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > bound) begin
        err_total++;
        stop_test();
      end
    end while (bout !== v);
  endtask

  task automatic hi_count(input logic sel_c, output int k);
    k = 0;
    repeat (10) begin
      @(negedge clk_sys);
      if ((sel_c ? mout : bout) === 1'b1) k++;
    end
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, A_BF, 32'h0, rd, er);
    chk("b func reset", rd, 32'h0);
    apb(1'b0, A_ST, 32'h0, rd, er);
    chk("status reset", rd, 32'h0);
    wr(A_BF, 32'h5);
    apb(1'b0, A_BF, 32'h0, rd, er);
    chk("b func", rd, 32'h5);
    wr(A_BC, 32'h2F3);
    apb(1'b0, A_BC, 32'h0, rd, er);
    chk("clock word", rd, 32'h2F3);
    apb(1'b1, 12'h100, 32'h7, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h1D9, 32'h0, rd, er);
    chk("unaligned err", {31'h0, er}, 32'h1);
    chk("unaligned data", rd, 32'h0);
    apb(1'b0, A_BF, 32'h0, rd, er);
    chk("b func kept", rd, 32'h5);
    wr(A_BC, 32'h0);
  endtask

  task automatic t_osc();
    logic [3:0] un[2]   = '{4'h2, 4'hF};
    logic [3:0] code[6] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'hD, 4'hE};
    int         per[6]  = '{2, 8, 3, 24, 5, 6};
    int         n;
    wr(A_BF, 32'h3);
    for (int i = 0; i < 2; i++) begin
      wr(A_BC, {28'h0, un[i]});
      @(posedge clk_sys);
      din <= ~din;
      wait_b(1'b1, 10, n);
      repeat (100) @(negedge clk_sys);
      chk("unused clock hold", {31'h0, bout}, 32'h1);
      wr(A_BC, 32'h0);
      wait_b(1'b0, 100, n);
    end
    for (int i = 0; i < 6; i++) begin
      wr(A_BC, {28'h0, code[i]});
      @(posedge clk_sys);
      din <= ~din;
      wait_b(1'b1, 10, n);
      chk("one shot rise", {31'h0, n <= 3}, 32'h1);
      wait_b(1'b0, 4000, n);
      chk("one shot width", {31'h0, n >= 15 * per[i] && n <= 18 * per[i] + 8},
          32'h1);
    end
    wr(A_BC, 32'h10);
    repeat (3) @(negedge clk_sys);
    chk("inverted idle", {31'h0, bout}, 32'h1);
    wr(A_BC, 32'h0);
  endtask

  task automatic t_det();
    logic [3:0] code[2] = '{4'hB, 4'h9};
    int         k, l0, l1;
    for (int i = 0; i < 2; i++) begin
      wr(A_BF, {28'h0, code[i]});
      @(posedge clk_sys);
      din <= 1'b0;
      repeat (5) @(negedge clk_sys);
      @(posedge clk_sys);
      din <= 1'b1;
      hi_count(1'b0, k);
      chk("detect rise", k, 32'h1);
      @(posedge clk_sys);
      din <= 1'b0;
      hi_count(1'b0, k);
      chk("detect fall", k, (i == 1) ? 32'h1 : 32'h0);
    end
    wr(A_BF, 32'hB);
    @(posedge clk_sys);
    din <= 1'b1;
    wait_b(1'b1, 10, l0);
    @(posedge clk_sys);
    din <= 1'b0;
    wr(A_BC, 32'h20);
    repeat (5) @(negedge clk_sys);
    @(posedge clk_sys);
    din <= 1'b1;
    wait_b(1'b1, 10, l1);
    chk("sync latency", l1, l0 + 2);
    wr(A_BC, 32'h0);
  endtask

  task automatic t_mcc();
    logic [2:0] ff[6]  = '{3'b111, 3'b010, 3'b011, 3'b110, 3'b111, 3'b101};
    logic       exp[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0] tbl    = 8'h96;
    int         k;
    wr(A_CW, 32'h9600);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      mx <= i[2:0];
      repeat (3) @(negedge clk_sys);
      chk("lut out", {31'h0, mout}, {31'h0, tbl[i]});
    end
    wr(A_BC, 32'h200);
    wr(A_CW, 32'h0);
    @(posedge clk_sys);
    mx <= 3'b110;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      mx <= ff[i];
      repeat (3) @(negedge clk_sys);
      chk("flop out", {31'h0, mout}, {31'h0, exp[i]});
    end
    wr(A_BC, 32'h0);
    wr(A_CW, 32'h4B);
    @(posedge clk_sys);
    mx <= 3'b000;
    repeat (5) @(negedge clk_sys);
    @(posedge clk_sys);
    mx <= 3'b100;
    hi_count(1'b1, k);
    chk("counter alone", k, 32'h1);
    wr(A_CW, 32'hF08B);
    @(posedge clk_sys);
    mx <= 3'b000;
    repeat (5) @(negedge clk_sys);
    @(posedge clk_sys);
    mx <= 3'b100;
    hi_count(1'b1, k);
    chk("counter into lut", k, 32'h1);
  endtask

  task automatic t_modes();
    int k;
    int n;
    int lo;
    lo = 2 * (CNT_TOP + 1);
    wr(A_BF, 32'h6);
    @(posedge clk_sys);
    din <= ~din;
    repeat (4) @(negedge clk_sys);
    chk("freq first edge", {31'h0, bout}, 32'h0);
    @(posedge clk_sys);
    din <= ~din;
    wait_b(1'b1, 10, n);
    chk("freq second edge", {31'h0, n <= 3}, 32'h1);
    wait_b(1'b0, 100, n);
    wr(A_BF, 32'hF);
    @(posedge clk_sys);
    din <= 1'b1;
    repeat (4) begin
      hi_count(1'b0, k);
      chk("level hold", k, 32'h0);
    end
    @(posedge clk_sys);
    din <= 1'b0;
    wait_b(1'b1, 60, n);
    chk("level wrap", {31'h0, n >= lo && n <= lo + 4}, 32'h1);
    wr(A_BC, 32'h40);
    wr(A_BF, 32'h2);
    repeat (3) @(negedge clk_sys);
    @(posedge clk_sys);
    din <= 1'b1;
    wait_b(1'b1, 60, n);
    chk("edge delay", {31'h0, n >= lo && n <= lo + 4}, 32'h1);
    hi_count(1'b0, k);
    chk("edge pulse width", k, 32'h0);
    wr(A_BC, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_osc();
    t_det();
    t_modes();
    t_mcc();
    stop_test();
  end
endmodule // tb_top

// ### verilog/mdc_pkg.sv
// Shared constants, types and mode decoding for the multifunction delay counter block.
package mdc_pkg;
  localparam logic [9:0]  IDX_B_FUNC   = 10'h076;
  localparam logic [9:0]  IDX_B_CLK    = 10'h077;
  localparam logic [9:0]  IDX_C_FUNC   = 10'h078;
  localparam logic [9:0]  IDX_STATUS   = 10'h07F;
  localparam int          INV_BIT      = 4;
  localparam int          SYNC_BIT     = 5;
  localparam int          DELAY_EDGE_DETECT_BIT     = 6;
  localparam int          INIT_LSB     = 7;
  localparam int          CFG_HI_BIT   = 9;
  localparam int          CFG_LO_LSB   = 4;
  localparam int          LUT_LSB      = 8;
  localparam logic [3:0]  RST_B_FUNC   = 4'h0;
  localparam logic [9:0]  RST_B_CLK    = 10'h000;
  localparam logic [15:0] RST_C_FUNC   = 16'h0000;
  localparam logic [7:0]  CNT_TOP      = 8'h0F;
  localparam logic [3:0]  CS_FAST      = 4'h0;
  localparam logic [3:0]  CS_FAST4     = 4'h1;
  localparam logic [3:0]  CS_SLOW      = 4'h6;
  localparam logic [3:0]  CS_SLOW8     = 4'h7;
  localparam logic [3:0]  CS_SLOW64    = 4'h8;
  localparam logic [3:0]  CS_SLOW512   = 4'h9;
  localparam logic [3:0]  CS_SLOW4K    = 4'hA;
  localparam logic [3:0]  CS_SLOW32K   = 4'hB;
  localparam logic [3:0]  CS_SLOW256K  = 4'hC;
  localparam logic [3:0]  CS_TERM_A    = 4'hD;
  localparam logic [3:0]  CS_EXT       = 4'hE;
  localparam logic [17:0] DIV8_MASK    = 18'h00007;
  localparam logic [17:0] DIV64_MASK   = 18'h0003F;
  localparam logic [17:0] DIV512_MASK  = 18'h001FF;
  localparam logic [17:0] DIV4K_MASK   = 18'h00FFF;
  localparam logic [17:0] DIV32K_MASK  = 18'h07FFF;
  localparam logic [17:0] DIV256K_MASK = 18'h3FFFF;
  localparam logic [4:0]  CFG_LUT      = 5'h00;
  localparam logic [4:0]  CFG_DFF      = 5'h10;
  localparam logic [4:0]  CFG_CNT      = 5'h04;
  localparam logic [4:0]  CFG_CNT_LUT  = 5'h08;
  localparam logic [4:0]  CFG_CNT_DFF  = 5'h18;

  typedef enum logic [2:0] {MDC_DELAY, MDC_ONESHOT, MDC_FREQ, MDC_DETECT, MDC_RESET} mdc_mode_t;
  typedef enum logic [1:0] {MDC_BOTH, MDC_FALL, MDC_RISE, MDC_LEVEL} mdc_edge_t;
  typedef struct packed {
    mdc_mode_t mode;
    mdc_edge_t edge_sel;
  } mdc_func_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mdc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mdc_apb_rsp_t;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } mdc_matrix_t;

  function automatic mdc_func_t mdc_decode(input logic [3:0] code);
    mdc_func_t f;
    f = '{MDC_DETECT, MDC_BOTH};
    case (code)
      4'h0: f = '{MDC_DELAY, MDC_BOTH};
      4'h1: f = '{MDC_DELAY, MDC_FALL};
      4'h2: f = '{MDC_DELAY, MDC_RISE};
      4'h3: f = '{MDC_ONESHOT, MDC_BOTH};
      4'h4: f = '{MDC_ONESHOT, MDC_FALL};
      4'h5: f = '{MDC_ONESHOT, MDC_RISE};
      4'h6: f = '{MDC_FREQ, MDC_BOTH};
      4'h7: f = '{MDC_FREQ, MDC_FALL};
      4'h8: f = '{MDC_FREQ, MDC_RISE};
      4'h9: f = '{MDC_DETECT, MDC_BOTH};
      4'hA: f = '{MDC_DETECT, MDC_FALL};
      4'hB: f = '{MDC_DETECT, MDC_RISE};
      4'hC: f = '{MDC_RESET, MDC_BOTH};
      4'hD: f = '{MDC_RESET, MDC_FALL};
      4'hE: f = '{MDC_RESET, MDC_RISE};
      default: f = '{MDC_RESET, MDC_LEVEL};
    endcase
    return f;
  endfunction
endpackage

// ### verilog/mdc_top.sv
// Two delay/counter channels with clock selection and macrocell C routing behind APB.
`timescale 1ns/1ps
module mdc_top (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire mdc_pkg::mdc_apb_req_t apb_req,
  output mdc_pkg::mdc_apb_rsp_t     apb_rsp,
  input  wire logic                 fast_osc_en,
  input  wire logic                 slow_osc_en,
  input  wire logic                 counter_a_terminal,
  input  wire logic                 external_count_clock,
  input  wire logic                 delay_input,
  input  wire mdc_pkg::mdc_matrix_t mcc_matrix,
  output logic                      counter_b_out,
  output logic                      mcc_out
);
  import mdc_pkg::*;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  mdc_apb_rsp_t rsp_r;
  logic [3:0]   b_func_r;
  logic [9:0]   b_clk_r;
  logic [15:0]  c_func_r;
  logic         init_ld_r;
  logic         b_out_r;
  logic         mcc_out_r;
  logic         dff_r;
  logic         mc_prev_r;
  logic         mb_prev_r;
  logic         ext_prev_r;
  logic [1:0]   fast4_r;
  logic [17:0]  pre_r;
  wire  [1:0]   ch_out;
  wire  [15:0]  ch_cnt;

  // APB decode; every access completes with one wait-free access phase.
  wire       setup   = apb_req.psel & ~apb_req.penable;
  wire [9:0] idx     = apb_req.paddr[11:2];
  wire       aligned = apb_req.paddr[1:0] == 2'h0;
  wire       hit_bf  = aligned & (idx == IDX_B_FUNC);
  wire       hit_bc  = aligned & (idx == IDX_B_CLK);
  wire       hit_cf  = aligned & (idx == IDX_C_FUNC);
  wire       hit_st  = aligned & (idx == IDX_STATUS);
  wire       mapped  = hit_bf | hit_bc | hit_cf | hit_st;
  wire       acc     = apb_req.psel & apb_req.penable & rsp_r.pready;
  wire       wr_ok   = acc & apb_req.pwrite & ~rsp_r.pslverr;
  wire       wr_bf   = wr_ok & hit_bf;
  wire       wr_bc   = wr_ok & hit_bc;
  wire       wr_cf   = wr_ok & hit_cf;
  wire [31:0] st_word = {13'h0000, ch_cnt, ch_out, mcc_out_r};
  wire [31:0] rd_data = hit_bf ? {28'h0000000, b_func_r} :
                        hit_bc ? {22'h000000, b_clk_r} :
                        hit_cf ? {16'h0000, c_func_r} :
                        hit_st ? st_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else if (setup) begin
      rsp_r.pready  <= 1'b1;
      rsp_r.pslverr <= ~mapped;
      rsp_r.prdata  <= apb_req.pwrite ? 32'h00000000 : rd_data;
    end else begin
      rsp_r <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      b_func_r  <= RST_B_FUNC;
      b_clk_r   <= RST_B_CLK;
      c_func_r  <= RST_C_FUNC;
      init_ld_r <= 1'b0;
    end else begin
      if (wr_bf) begin
        b_func_r <= apb_req.pwdata[3:0];
      end
      if (wr_bc) begin
        b_clk_r <= apb_req.pwdata[9:0];
      end
      if (wr_cf) begin
        c_func_r <= apb_req.pwdata[15:0];
      end
      init_ld_r <= wr_bc;
    end
  end

  // Configuration fields.
  wire [3:0] b_csel  = b_clk_r[3:0];
  wire       b_inv   = b_clk_r[INV_BIT];
  wire [1:0] c_init  = b_clk_r[INIT_LSB+1:INIT_LSB];
  wire [4:0] cfg     = {b_clk_r[CFG_HI_BIT], c_func_r[CFG_LO_LSB+3:CFG_LO_LSB]};
  wire [7:0] lut_tbl = c_func_r[LUT_LSB+7:LUT_LSB];

  // Clock taps: fast divided by four, slow through one prescaler.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fast4_r    <= 2'h0;
      pre_r      <= 18'h00000;
      ext_prev_r <= 1'b0;
    end else begin
      if (fast_osc_en) begin
        fast4_r <= fast4_r + 2'h1;
      end
      if (slow_osc_en) begin
        pre_r <= pre_r + 18'h00001;
      end
      ext_prev_r <= external_count_clock;
    end
  end

  wire fast4_tick = fast_osc_en & (fast4_r == 2'h3);
  wire s8_tick    = slow_osc_en & ((pre_r & DIV8_MASK) == DIV8_MASK);
  wire s64_tick   = slow_osc_en & ((pre_r & DIV64_MASK) == DIV64_MASK);
  wire s512_tick  = slow_osc_en & ((pre_r & DIV512_MASK) == DIV512_MASK);
  wire s4k_tick   = slow_osc_en & ((pre_r & DIV4K_MASK) == DIV4K_MASK);
  wire s32k_tick  = slow_osc_en & ((pre_r & DIV32K_MASK) == DIV32K_MASK);
  wire s256k_tick = slow_osc_en & ((pre_r & DIV256K_MASK) == DIV256K_MASK);
  wire ext_tick   = external_count_clock & ~ext_prev_r;

  // Counter B clock source; unused codes give no tick at all.
  wire tick_b = (b_csel == CS_FAST)     ? fast_osc_en :
                (b_csel == CS_FAST4)    ? fast4_tick :
                (b_csel == CS_SLOW)     ? slow_osc_en :
                (b_csel == CS_SLOW8)    ? s8_tick :
                (b_csel == CS_SLOW64)   ? s64_tick :
                (b_csel == CS_SLOW512)  ? s512_tick :
                (b_csel == CS_SLOW4K)   ? s4k_tick :
                (b_csel == CS_SLOW32K)  ? s32k_tick :
                (b_csel == CS_SLOW256K) ? s256k_tick :
                (b_csel == CS_TERM_A)   ? counter_a_terminal :
                (b_csel == CS_EXT)      ? ext_tick : 1'b0;

  // Macrocell C routing between the three matrix inputs.
  wire is_lut     = cfg == CFG_LUT;
  wire is_dff     = cfg == CFG_DFF;
  wire is_cnt     = cfg == CFG_CNT;
  wire is_cnt_lut = cfg == CFG_CNT_LUT;
  wire is_cnt_dff = cfg == CFG_CNT_DFF;
  wire cnt_used   = is_cnt | is_cnt_lut | is_cnt_dff;
  wire delay_input_c   = cnt_used ? mcc_matrix.a : 1'b0;
  wire lut_in2    = is_cnt_lut ? ch_out[1] : mcc_matrix.a;
  wire lut_y      = lut_tbl[{lut_in2, mcc_matrix.b, mcc_matrix.c}];
  wire dff_d      = is_cnt_dff ? ch_out[1] : mcc_matrix.a;
  wire mb_tick    = mcc_matrix.b & ~mb_prev_r;
  wire tick_c     = is_cnt ? mb_tick : fast_osc_en;
  wire mcc_nxt    = is_cnt ? ch_out[1] :
                    (is_lut | is_cnt_lut) ? lut_y :
                    (is_dff | is_cnt_dff) ? dff_r : 1'b0;

  // Flop with active-low reset from matrix B, clocked by matrix C rising.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dff_r     <= 1'b0;
      mc_prev_r <= 1'b0;
      mb_prev_r <= 1'b0;
    end else begin
      mc_prev_r <= mcc_matrix.c;
      mb_prev_r <= mcc_matrix.b;
      if (!mcc_matrix.b) begin
        dff_r <= 1'b0;
      end else if (mcc_matrix.c & ~mc_prev_r) begin
        dff_r <= dff_d;
      end
    end
  end

  // Per-channel controls: index 0 is counter B, index 1 is counter C.
  wire [1:0] in_raw  = {delay_input_c, delay_input};
  wire [1:0] tick    = {tick_c, tick_b};
  wire [1:0] sync_en = {1'b0, b_clk_r[SYNC_BIT]};
  wire [1:0] delay_edge_detect_en = {1'b0, b_clk_r[DELAY_EDGE_DETECT_BIT]};
  wire [1:0] init_ld = {init_ld_r & (c_init != 2'h0), 1'b0};
  wire [1:0] init_vl = {c_init[1], 1'b0};
  mdc_func_t fn [2];
  assign fn[0] = mdc_decode(b_func_r);
  assign fn[1] = mdc_decode(c_func_r[3:0]);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic       s1_r;
      logic       s2_r;
      logic       prev_r;
      logic       busy_r;
      logic       out_r;
      logic [7:0] cnt_r;
      wire in_use = sync_en[gi] ? s2_r : in_raw[gi];
      wire rise   = in_use & ~prev_r;
      wire fall   = ~in_use & prev_r;
      wire trig   = (fn[gi].edge_sel == MDC_BOTH)  ? (rise | fall) :
                    (fn[gi].edge_sel == MDC_FALL)  ? fall :
                    (fn[gi].edge_sel == MDC_RISE)  ? rise : in_use;
      wire at_top = cnt_r == CNT_TOP;
      wire expire = tick[gi] & busy_r & at_top;
      wire run    = tick[gi] & busy_r & ~at_top;
      wire delay_edge_detect   = delay_edge_detect_en[gi];

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= in_raw[gi];
          s2_r <= s1_r;
        end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          prev_r <= 1'b0;
          busy_r <= 1'b0;
          out_r  <= 1'b0;
          cnt_r  <= 8'h00;
        end else begin
          prev_r <= in_use;
          case (fn[gi].mode)
            MDC_DELAY: begin
              if (trig) begin
                busy_r <= 1'b1;
                cnt_r  <= 8'h00;
              end else if (rise | fall) begin
                busy_r <= 1'b0;
                out_r  <= delay_edge_detect ? 1'b0 : in_use;
              end else if (expire) begin
                busy_r <= 1'b0;
                out_r  <= delay_edge_detect ? 1'b1 : in_use;
              end else begin
                if (run) begin
                  cnt_r <= cnt_r + 8'h01;
                end
                if (delay_edge_detect) begin
                  out_r <= 1'b0;
                end
              end
            end
            MDC_ONESHOT: begin
              if (trig) begin
                out_r  <= 1'b1;
                busy_r <= 1'b1;
                cnt_r  <= 8'h00;
              end else if (expire) begin
                out_r  <= 1'b0;
                busy_r <= 1'b0;
              end else if (run) begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
            MDC_FREQ: begin
              if (trig) begin
                out_r  <= busy_r;
                busy_r <= 1'b1;
                cnt_r  <= 8'h00;
              end else if (expire) begin
                out_r  <= 1'b0;
                busy_r <= 1'b0;
              end else if (run) begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
            MDC_DETECT: begin
              out_r <= trig;
            end
            MDC_RESET: begin
              busy_r <= 1'b0;
              if (trig) begin
                cnt_r <= 8'h00;
                out_r <= 1'b0;
              end else if (tick[gi]) begin
                cnt_r <= at_top ? 8'h00 : cnt_r + 8'h01;
                out_r <= at_top;
              end else begin
                out_r <= 1'b0;
              end
            end
            default: begin
              busy_r <= 1'b0;
            end
          endcase
          if (init_ld[gi]) begin
            out_r <= init_vl[gi];
          end
        end
      end

      assign ch_out[gi]          = out_r;
      assign ch_cnt[gi*8 +: 8]   = cnt_r;

      sequence sync_held;
        sync_en[gi] [*3];
      endsequence

      oneshot_start_a: assert property (
        (fn[gi].mode == MDC_ONESHOT) && trig && !init_ld[gi] |=> out_r && (cnt_r == 8'h00))
        else $error("One-shot did not start on its trigger edge.");
      freq_first_a: assert property (
        (fn[gi].mode == MDC_FREQ) && trig && !busy_r && !init_ld[gi] |=> !out_r && busy_r)
        else $error("First frequency edge must not raise the output.");
      detect_pulse_a: assert property (
        (fn[gi].mode == MDC_DETECT) && trig && !init_ld[gi] |=> out_r)
        else $error("Edge detector missed a trigger edge.");
      level_reset_a: assert property (
        (fn[gi].mode == MDC_RESET) && (fn[gi].edge_sel == MDC_LEVEL) && in_use
        |=> cnt_r == 8'h00)
        else $error("Counter not held cleared while input is high.");
      sync_delay_a: assert property (
        sync_held |-> in_use == $past(in_raw[gi], 2))
        else $error("Synchronised input is not two cycles late.");
      init_level_a: assert property (
        init_ld[gi] |=> out_r == $past(init_vl[gi]))
        else $error("Initial output level not applied.");
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      b_out_r   <= 1'b0;
      mcc_out_r <= 1'b0;
    end else begin
      b_out_r   <= ch_out[0] ^ b_inv;
      mcc_out_r <= mcc_nxt;
    end
  end

  assign apb_rsp       = rsp_r;
  assign counter_b_out = b_out_r;
  assign mcc_out       = mcc_out_r;

  sequence apb_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  apb_ready_a: assert property (apb_setup |=> rsp_r.pready)
    else $error("APB access phase not answered at once.");
  clk_unused_a: assert property (
    (b_csel inside {4'h2, 4'h3, 4'h4, 4'h5, 4'hF}) |-> !tick_b)
    else $error("Unused clock code produced a count tick.");
  clk_fast4_a: assert property (
    (b_csel == CS_FAST4) && tick_b |-> fast_osc_en ##1 (fast4_r == 2'h0))
    else $error("Fast divided clock tick out of phase.");
  clk_term_a: assert property (
    (b_csel == CS_TERM_A) |-> tick_b == counter_a_terminal)
    else $error("Counter A terminal not used as clock.");
  invert_out_a: assert property (
    1'b1 |=> counter_b_out == ($past(ch_out[0]) ^ $past(b_inv)))
    else $error("Counter B output polarity wrong.");
  route_single_a: assert property (
    (is_lut || is_dff) |-> !delay_input_c)
    else $error("Counter input not held low in single LUT or flop mode.");
  route_cnt_a: assert property (
    is_cnt |=> mcc_out == $past(ch_out[1]))
    else $error("Counter output not routed in single counter mode.");
  route_chain_a: assert property (
    is_cnt_lut |-> lut_in2 == ch_out[1] && delay_input_c == mcc_matrix.a)
    else $error("Counter not chained into the lookup table.");
endmodule // mdc_top
